// >>> pmt_phy.sv
// pmt_phy: transceiver end, makes the transmit clock and encodes samples
// assumes: the controller keeps unused data pins low in rmii mode
`default_nettype none

module pmt_phy #(
    parameter int AN_CYC = pmt_pkg::AN_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    pmt_if.phy              lnk,
    input  wire logic       interface_select_strap,
    input  wire logic       irq_select_strap,
    input  wire logic       symbol_mode,
    input  wire logic       an_enable,
    input  wire logic [3:0] local_ability,
    input  wire logic [3:0] partner_ability,
    input  wire logic       partner_present,
    input  wire logic       forced_speed_100,
    input  wire logic       forced_full,
    input  wire logic       irq_clear,
    output logic      [4:0] code_out,
    output logic            code_valid,
    output logic            code_error,
    output logic            speed_100,
    output logic            full_duplex,
    output logic            link_up,
    output logic            rmii_mode
);

    typedef enum logic [2:0] {
        AN_IDLE = 3'h1,
        AN_WAIT = 3'h2,
        AN_LINK = 3'h4
    } pmt_an_e;

    function automatic logic [4:0] enc_4b5b(input logic [3:0] nib);
        case (nib)
            4'h0: enc_4b5b = 5'h1e;
            4'h1: enc_4b5b = 5'h09;
            4'h2: enc_4b5b = 5'h14;
            4'h3: enc_4b5b = 5'h15;
            4'h4: enc_4b5b = 5'h0a;
            4'h5: enc_4b5b = 5'h0b;
            4'h6: enc_4b5b = 5'h0e;
            4'h7: enc_4b5b = 5'h0f;
            4'h8: enc_4b5b = 5'h12;
            4'h9: enc_4b5b = 5'h13;
            4'ha: enc_4b5b = 5'h16;
            4'hb: enc_4b5b = 5'h17;
            4'hc: enc_4b5b = 5'h1a;
            4'hd: enc_4b5b = 5'h1b;
            4'he: enc_4b5b = 5'h1c;
            default: enc_4b5b = 5'h1d;
        endcase
    endfunction : enc_4b5b

    // returns {ok, speed_100, full}; ok low when nothing is in common
    function automatic logic [2:0] best_mode(input logic [3:0] ab);
        if (ab[pmt_pkg::ABL_100F])
            best_mode = 3'h7;
        else if (ab[pmt_pkg::ABL_100H])
            best_mode = 3'h6;
        else if (ab[pmt_pkg::ABL_10F])
            best_mode = 3'h5;
        else if (ab[pmt_pkg::ABL_10H])
            best_mode = 3'h4;
        else
            best_mode = 3'h0;
    endfunction : best_mode

    // ****************************************
    // synchronisers
    // ****************************************
    logic [12:0] pin_s1;
    logic [12:0] pin_s2;
    always_ff @(posedge core_clk)
    begin
        pin_s1 <= {partner_ability, partner_present, irq_select_strap,
                   interface_select_strap, lnk.tx_er, lnk.tx_en, lnk.txd};
        pin_s2 <= pin_s1;
    end

    logic [3:0] txd_s;
    logic       en_s;
    logic       er_s;
    logic       symbol_msb_in;
    logic       partner_s;
    logic [3:0] partner_ab_s;
    assign txd_s         = pin_s2[3:0];
    assign en_s          = pin_s2[4];
    assign er_s          = pin_s2[5];
    assign symbol_msb_in = pin_s2[5];
    assign partner_s     = pin_s2[8];
    assign partner_ab_s  = pin_s2[12:9];

    // ****************************************
    // strap latch after reset release
    // ****************************************
    logic [1:0] strap_cnt;
    logic       irq_fn_link;
    logic       strap_done;
    assign strap_done = strap_cnt == 2'(pmt_pkg::STRAP_LATCH_CYC);
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            strap_cnt   <= 2'h0;
            rmii_mode   <= 1'b0;
            irq_fn_link <= 1'b0;
        end
        else if (strap_cnt != 2'(pmt_pkg::STRAP_LATCH_CYC))
        begin
            strap_cnt <= strap_cnt + 2'h1;
            // sync chain needs two edges to refill after reset
            if (strap_cnt == 2'(pmt_pkg::STRAP_LATCH_CYC - 1))
            begin
                rmii_mode   <= pin_s2[6];
                irq_fn_link <= pin_s2[7];
            end
        end
    end

    // ****************************************
    // auto-negotiation
    // ****************************************
    pmt_an_e    an_state;
    logic [15:0] an_cnt;
    logic [2:0]  an_pick;
    logic        link_ev;
    assign an_pick = best_mode(local_ability & partner_ab_s);
    assign link_ev = (an_state == AN_WAIT && an_cnt == 16'(AN_CYC - 1) && an_pick[2])
                     || (an_state == AN_LINK && !partner_s);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            an_state    <= AN_IDLE;
            an_cnt      <= 16'h0000;
            link_up     <= 1'b0;
            speed_100   <= 1'b0;
            full_duplex <= 1'b0;
        end
        else
            case (an_state)
                AN_IDLE:
                    if (partner_s && !an_enable)
                    begin
                        an_state    <= AN_LINK;
                        link_up     <= 1'b1;
                        speed_100   <= forced_speed_100;
                        full_duplex <= forced_full;
                    end
                    else if (partner_s)
                    begin
                        an_state <= AN_WAIT;
                        an_cnt   <= 16'h0000;
                    end
                AN_WAIT:
                    if (!partner_s)
                        an_state <= AN_IDLE;
                    else if (an_cnt != 16'(AN_CYC - 1))
                        an_cnt <= an_cnt + 16'h0001;
                    else if (an_pick[2])
                    begin
                        an_state    <= AN_LINK;
                        link_up     <= 1'b1;
                        speed_100   <= an_pick[1];
                        full_duplex <= an_pick[0];
                    end
                    else
                        an_cnt <= 16'h0000;
                AN_LINK:
                    if (!partner_s)
                    begin
                        an_state <= AN_IDLE;
                        link_up  <= 1'b0;
                    end
                default:
                    an_state <= AN_IDLE;
            endcase
    end

    // ****************************************
    // transmit clock divider
    // ****************************************
    logic [4:0] div_cnt;
    logic       clk_ph;
    logic       tick;
    logic       rise;
    // at or above the limit: a drop in half period never wraps the counter
    assign tick = div_cnt >= 5'(speed_100 ? pmt_pkg::HALF_100 - 1 : pmt_pkg::HALF_10 - 1);
    assign rise = tick && !clk_ph;

    always_ff @(posedge core_clk)
    begin
        // held until the straps are in, so the unused clock pin never glitches
        if (srst || !strap_done)
        begin
            div_cnt     <= 5'h00;
            clk_ph      <= 1'b0;
            lnk.tx_clk  <= 1'b0;
            lnk.ref_clk <= 1'b0;
        end
        else
        begin
            div_cnt     <= tick ? 5'h00 : div_cnt + 5'h01;
            clk_ph      <= tick ? !clk_ph : clk_ph;
            // clock pin idles low in the unused mode
            lnk.tx_clk  <= !rmii_mode && (tick ? !clk_ph : clk_ph);
            lnk.ref_clk <= rmii_mode && (tick ? !clk_ph : clk_ph);
        end
    end

    // ****************************************
    // sampling and encoding
    // ****************************************
    logic       half;
    logic [1:0] low_dibit;
    logic [3:0] rmii_nib;
    assign rmii_nib = {txd_s[1:0], low_dibit};

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            code_out   <= 5'h00;
            code_valid <= 1'b0;
            code_error <= 1'b0;
            half       <= 1'b0;
            low_dibit  <= 2'b00;
        end
        else
        begin
            code_valid <= 1'b0;
            code_error <= 1'b0;
            if (!en_s)
                half <= 1'b0;
            else if (rise && !rmii_mode)
            begin
                code_valid <= 1'b1;
                if (symbol_mode)
                    code_out <= {symbol_msb_in, txd_s};
                else if (!speed_100)
                    code_out <= {1'b0, txd_s};
                else if (er_s)
                begin
                    code_out   <= pmt_pkg::CODE_H;
                    code_error <= 1'b1;
                end
                else
                    code_out <= enc_4b5b(txd_s);
            end
            else if (rise)
            begin
                half      <= !half;
                low_dibit <= txd_s[1:0];
                if (half)
                begin
                    code_valid <= 1'b1;
                    code_out   <= speed_100 ? enc_4b5b(rmii_nib) : {1'b0, rmii_nib};
                end
            end
        end
    end

    // ****************************************
    // interrupt pin
    // ****************************************
    logic irq_pend;
    always_ff @(posedge core_clk)
    begin
        if (srst)
            irq_pend <= 1'b0;
        else if (link_ev || code_error)
            irq_pend <= 1'b1;
        else if (irq_clear)
            irq_pend <= 1'b0;
    end

    // open drain: only ever pulls low
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            lnk.interrupt_n_out <= 1'b0;
            lnk.interrupt_n_oe  <= 1'b0;
        end
        else
        begin
            lnk.interrupt_n_out <= 1'b0;
            lnk.interrupt_n_oe  <= irq_fn_link ? link_up : irq_pend;
        end
    end

endmodule : pmt_phy

`default_nettype wire

// >>> pmt_pkg.sv
// pmt_pkg: constants shared by both ends of the mii/rmii transmit port
// assumes: both ends run on one 100 MHz core clock with a synchronous reset
`default_nettype none

package pmt_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CORE_CLK_HZ     = 100_000_000;
    localparam int TXCLK_100_HZ    = 25_000_000;
    localparam int TXCLK_10_HZ     = 2_500_000;
    localparam int HALF_100        = CORE_CLK_HZ / (2 * TXCLK_100_HZ);
    localparam int HALF_10         = CORE_CLK_HZ / (2 * TXCLK_10_HZ);
    localparam int AN_TIME_US      = 10;
    localparam int AN_CYCLES       = AN_TIME_US * (CORE_CLK_HZ / 1_000_000);
    localparam int STRAP_LATCH_CYC = 2;

    // ****************************************
    // code groups and abilities
    // ****************************************
    localparam logic [4:0] CODE_H   = 5'h04;
    localparam int         ABL_10H  = 0;
    localparam int         ABL_10F  = 1;
    localparam int         ABL_100H = 2;
    localparam int         ABL_100F = 3;

    // ****************************************
    // controller registers
    // ****************************************
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_TXDATA   = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam int         CTRL_RMII    = 0;
    localparam int         CTRL_SYMBOL  = 1;
    localparam int         CTRL_ERR     = 2;
    localparam logic [2:0] CTRL_RST     = 3'h0;
    localparam int         ST_FULL      = 0;
    localparam int         ST_SENDING   = 1;
    localparam int         ST_PHY_IRQ   = 2;
    localparam int         EV_TAKEN     = 0;
    localparam int         EV_FRAME_END = 1;
    localparam int         EV_OVERRUN   = 2;
    localparam int         EV_PHY_IRQ   = 3;
    localparam logic [3:0] IRQ_RST      = 4'h0;

endpackage : pmt_pkg

`default_nettype wire

// >>> pmt_if.sv
// pmt_if: transmit pins between controller and transceiver
// assumes: open-drain interrupt line has a pull-up, modelled here
`default_nettype none

interface pmt_if;
    logic       tx_clk;
    logic       ref_clk;
    logic [3:0] txd;
    logic       tx_en;
    logic       tx_er;
    logic       interrupt_n_out;
    logic       interrupt_n_oe;
    logic       interrupt_n_level;

    // pull-up gives the inactive level
    assign interrupt_n_level = interrupt_n_oe ? interrupt_n_out : 1'b1;

    modport phy (
        output tx_clk,
        output ref_clk,
        input  txd,
        input  tx_en,
        input  tx_er,
        output interrupt_n_out,
        output interrupt_n_oe
    );

    modport mac (
        input  tx_clk,
        input  ref_clk,
        output txd,
        output tx_en,
        output tx_er,
        input  interrupt_n_level
    );
endinterface : pmt_if

`default_nettype wire

// >>> pmt_mac.sv
// pmt_mac: controller end, sends bytes or symbols over the transmit pins
// assumes: register master per plain strobe port; link clocks come from the phy
`default_nettype none

module pmt_mac (
    input  wire logic        core_clk,
    input  wire logic        srst,
    pmt_if.mac               lnk,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_prev;
    always_ff @(posedge core_clk)
    begin
        pin_s1   <= {lnk.interrupt_n_level, lnk.ref_clk, lnk.tx_clk};
        pin_s2   <= pin_s1;
        pin_prev <= pin_s2;
    end

    logic [2:0] ctrl;
    logic       rmii;
    logic       sym;
    logic       rise;
    logic       phy_fall;
    assign rmii     = ctrl[pmt_pkg::CTRL_RMII];
    assign sym      = ctrl[pmt_pkg::CTRL_SYMBOL];
    assign rise     = rmii ? (pin_s2[1] & ~pin_prev[1]) : (pin_s2[0] & ~pin_prev[0]);
    assign phy_fall = pin_prev[2] & ~pin_s2[2];

    // ****************************************
    // registers
    // ****************************************
    logic [2:0] units;
    logic [7:0] hold;
    logic       hold_full;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [3:0] ev;
    logic       wr_data;
    logic       load;
    assign wr_data = reg_wr && (reg_addr == pmt_pkg::REG_TXDATA);
    assign load    = rise && (units == 3'h0) && hold_full;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ctrl     <= pmt_pkg::CTRL_RST;
            irq_mask <= pmt_pkg::IRQ_RST;
        end
        else if (reg_wr && reg_addr == pmt_pkg::REG_CTRL)
            ctrl <= reg_wdata[2:0];
        else if (reg_wr && reg_addr == pmt_pkg::REG_IRQ_MASK)
            irq_mask <= reg_wdata[3:0];
    end

    // one-word holding register; a write while full is dropped
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            hold      <= 8'h00;
            hold_full <= 1'b0;
        end
        else if (wr_data && !hold_full)
        begin
            hold      <= reg_wdata[7:0];
            hold_full <= 1'b1;
        end
        else if (load)
            hold_full <= 1'b0;
    end

    // set wins over write-one-to-clear
    always_ff @(posedge core_clk)
    begin
        if (srst)
            irq_stat <= pmt_pkg::IRQ_RST;
        else if (reg_wr && reg_addr == pmt_pkg::REG_IRQ_STAT)
            irq_stat <= (irq_stat & ~reg_wdata[3:0]) | ev;
        else
            irq_stat <= irq_stat | ev;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= |(irq_stat & irq_mask);
    end

    always_ff @(posedge core_clk)
    begin
        if (srst || !reg_rd)
            reg_rdata <= 32'h0000_0000;
        else
            case (reg_addr)
                pmt_pkg::REG_CTRL:     reg_rdata <= {29'h0000_0000, ctrl};
                pmt_pkg::REG_TXDATA:   reg_rdata <= {24'h00_0000, hold};
                pmt_pkg::REG_STATUS:   reg_rdata <= {29'h0000_0000, ~pin_s2[2], lnk.tx_en,
                                                     hold_full};
                pmt_pkg::REG_IRQ_STAT: reg_rdata <= {28'h000_0000, irq_stat};
                pmt_pkg::REG_IRQ_MASK: reg_rdata <= {28'h000_0000, irq_mask};
                default:               reg_rdata <= 32'h0000_0000;
            endcase
    end

    // ****************************************
    // transmit shifter, one unit per link clock rise
    // ****************************************
    logic [7:0] shreg;
    logic [7:0] word;
    assign word = load ? hold : shreg;

    always_comb
    begin
        ev = 4'h0;
        ev[pmt_pkg::EV_TAKEN]     = load;
        ev[pmt_pkg::EV_FRAME_END] = rise && units == 3'h0 && !hold_full && lnk.tx_en;
        ev[pmt_pkg::EV_OVERRUN]   = wr_data && hold_full;
        ev[pmt_pkg::EV_PHY_IRQ]   = phy_fall;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            shreg     <= 8'h00;
            units     <= 3'h0;
            lnk.txd   <= 4'h0;
            lnk.tx_en <= 1'b0;
            lnk.tx_er <= 1'b0;
        end
        else if (rise && (units != 3'h0 || hold_full))
        begin
            lnk.tx_en <= 1'b1;
            if (sym)
            begin
                lnk.txd   <= word[3:0];
                lnk.tx_er <= word[4];
                units     <= 3'h0;
            end
            else if (rmii)
            begin
                lnk.txd   <= {2'b00, word[1:0]};
                lnk.tx_er <= 1'b0;
                shreg     <= {2'b00, word[7:2]};
                units     <= load ? 3'h3 : units - 3'h1;
            end
            else
            begin
                lnk.txd   <= word[3:0];
                lnk.tx_er <= ctrl[pmt_pkg::CTRL_ERR];
                shreg     <= {4'h0, word[7:4]};
                units     <= load ? 3'h1 : units - 3'h1;
            end
        end
        else if (rise)
        begin
            lnk.tx_en <= 1'b0;
            lnk.txd   <= 4'h0;
            lnk.tx_er <= 1'b0;
        end
    end

endmodule : pmt_mac

`default_nettype wire

// >>> pmt_unused_marker.sv
`default_nettype none
`default_nettype wire

// >>> pmt_link_assertions.sv
// pmt_link_checker: concurrent checks on the transmit pins between both ends
// assumes: one core clock domain, synchronous active-high reset
`default_nettype none

module pmt_link_checker (
    input wire logic       core_clk,
    input wire logic       srst,
    input wire logic       tx_clk,
    input wire logic       ref_clk,
    input wire logic [3:0] txd,
    input wire logic       tx_en,
    input wire logic       tx_er,
    input wire logic       interrupt_n_out,
    input wire logic       interrupt_n_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // ****************************************
    // link clock and unit framing
    // ****************************************
    a_reset_quiet: assert property ($fell(srst) |-> !tx_clk && !interrupt_n_oe && !tx_en)
        else $error("link pins busy at reset release");
    a_clk_high_min: assert property ($rose(tx_clk) |-> tx_clk[*2])
        else $error("transmit clock high too short");
    // wide bound: the divider may restart its phase when the speed changes
    a_clk_high_max: assert property ($rose(tx_clk) |-> ##[1:44] !tx_clk)
        else $error("transmit clock stuck high");
    a_clk_low_min: assert property ($fell(tx_clk) |-> !tx_clk[*2])
        else $error("transmit clock low too short");
    a_clk_low_max: assert property ($fell(tx_clk) |-> ##[1:44] tx_clk)
        else $error("transmit clock stuck low");
    a_clk_single: assert property (!(tx_clk && ref_clk))
        else $error("both link clocks driven");
    a_en_min_len: assert property ($rose(tx_en) |-> tx_en[*4])
        else $error("enable shorter than one unit");
    a_data_hold: assert property ($changed(txd) |=> $stable(txd)[*3])
        else $error("data unit not held a link period");
    a_err_hold: assert property ($changed(tx_er) |=> $stable(tx_er)[*3])
        else $error("error bit not held a link period");
    a_irq_pin_low: assert property (interrupt_n_out == 1'b0)
        else $error("interrupt pin driven high");
    a_rmii_upper_low: assert property (ref_clk |-> txd[3:2] == 2'b00)
        else $error("upper data pins driven in rmii");

    c_frame: cover property ($rose(tx_en));
    c_err: cover property ($rose(tx_er));
    c_irq: cover property ($rose(interrupt_n_oe));
endmodule : pmt_link_checker

`default_nettype wire

// >>> testbench.sv
// testbench: controller and transceiver joined by the link interface
// assumes: both ends on core_clk; straps low until the closing rmii part
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk;
    logic        srst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        irq;
    logic        an_enable;
    logic [3:0]  partner_ability;
    logic        partner_present;
    logic        forced_speed_100;
    logic        forced_full;
    logic        irq_clear;
    logic [4:0]  code_out;
    logic        code_valid;
    logic        code_error;
    logic        speed_100;
    logic        full_duplex;
    logic        link_up;
    logic        rmii_mode;
    logic        iface_strap;
    logic        irq_strap;
    logic        symbol_mode;
    logic [31:0] v;
    logic [4:0]  codes[$];
    logic        errs[$];
    int          checked;
    int          miscompares;

    pmt_if lnk_if ();
    pmt_mac pmt_mac_inst (.core_clk(core_clk), .srst(srst), .lnk(lnk_if.mac),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    // short negotiation keeps the run brief
    pmt_phy #(.AN_CYC(20)) pmt_phy_inst (.core_clk(core_clk), .srst(srst),
        .lnk(lnk_if.phy), .interface_select_strap(iface_strap), .irq_select_strap(irq_strap),
        .symbol_mode(symbol_mode), .an_enable(an_enable), .local_ability(4'hf),
        .partner_ability(partner_ability), .partner_present(partner_present),
        .forced_speed_100(forced_speed_100), .forced_full(forced_full),
        .irq_clear(irq_clear), .code_out(code_out), .code_valid(code_valid),
        .code_error(code_error), .speed_100(speed_100), .full_duplex(full_duplex),
        .link_up(link_up), .rmii_mode(rmii_mode));
    pmt_link_checker pmt_link_checker_inst (.core_clk(core_clk), .srst(srst),
        .tx_clk(lnk_if.tx_clk), .ref_clk(lnk_if.ref_clk), .txd(lnk_if.txd),
        .tx_en(lnk_if.tx_en), .tx_er(lnk_if.tx_er),
        .interrupt_n_out(lnk_if.interrupt_n_out), .interrupt_n_oe(lnk_if.interrupt_n_oe));

    // ****************************************
    // clock, code capture, helpers
    // ****************************************
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
        if (code_valid === 1'b1)
        begin
            codes.push_back(code_out);
            errs.push_back(code_error);
        end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic wait_link(input logic up);
        for (int i = 0; i < 300 && link_up !== up; i++)
            @(posedge core_clk);
        check(32'(link_up), 32'(up));
    endtask : wait_link

    // sends one write and waits for its n code groups
    task automatic send(input logic [7:0] b, input int n = 2);
        codes.delete();
        errs.delete();
        wr(pmt_pkg::REG_TXDATA, {24'h0000_00, b});
        for (int i = 0; i < 2000 && codes.size() < n; i++)
            @(posedge core_clk);
        check(32'(codes.size()), 32'(n));
        repeat (100) @(posedge core_clk);
    endtask : send

    // rising edges of the transmit clock over a fixed span
    task automatic count_rises(input int span, input int exp);
        int   n;
        logic last;
        // a speed change may leave one odd half period
        repeat (40) @(posedge core_clk);
        n    = 0;
        last = lnk_if.tx_clk;
        repeat (span)
        begin
            @(posedge core_clk);
            if (lnk_if.tx_clk === 1'b1 && last === 1'b0)
                n++;
            last = lnk_if.tx_clk;
        end
        check(32'(n), 32'(exp));
    endtask : count_rises

    task automatic summarize;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    initial
    begin
        #100us;
        miscompares++;
        summarize();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        checked = 0;
        miscompares = 0;
        srst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, irq_clear, iface_strap, irq_strap, symbol_mode} = '0;
        {an_enable, partner_present, partner_ability} = {2'b11, 4'hf};
        {forced_speed_100, forced_full} = 2'b00;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        rd(pmt_pkg::REG_CTRL);
        check(v, 32'h0000_0000);
        rd(pmt_pkg::REG_IRQ_MASK);
        check(v, 32'h0000_0000);
        rd(8'h20);
        check(v, 32'h0000_0000);
        wait_link(1'b1);
        check(32'({speed_100, full_duplex}), 32'h0000_0003);
        repeat (2) @(posedge core_clk);
        check(32'(lnk_if.interrupt_n_level), 32'h0000_0000);
        @(posedge core_clk) irq_clear <= 1'b1;
        @(posedge core_clk) irq_clear <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(32'(lnk_if.interrupt_n_level), 32'h0000_0001);
        count_rises(80, 20);
        wr(pmt_pkg::REG_IRQ_STAT, 32'h0000_000f);
        send(8'ha5);
        check(32'(codes[0]), 32'h0000_000b);
        check(32'(codes[1]), 32'h0000_0016);
        check(32'(errs[0] | errs[1]), 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
        rd(pmt_pkg::REG_IRQ_STAT);
        check(v, 32'h0000_0003);
        wr(pmt_pkg::REG_IRQ_MASK, 32'h0000_0003);
        rd(pmt_pkg::REG_IRQ_STAT);
        check(32'(irq), 32'h0000_0001);
        wr(pmt_pkg::REG_IRQ_STAT, 32'h0000_0001);
        rd(pmt_pkg::REG_IRQ_STAT);
        check(v, 32'h0000_0002);
        wr(pmt_pkg::REG_IRQ_STAT, 32'h0000_0002);
        rd(pmt_pkg::REG_IRQ_STAT);
        check(32'(irq), 32'h0000_0000);
        wr(pmt_pkg::REG_CTRL, 32'h0000_0004);
        send(8'h00);
        check(32'(codes[0]), 32'(pmt_pkg::CODE_H));
        check(32'(errs[1]), 32'h0000_0001);
        rd(pmt_pkg::REG_STATUS);
        check(v, 32'h0000_0004);
        check(32'(lnk_if.interrupt_n_level), 32'h0000_0000);
        partner_present <= 1'b0;
        wait_link(1'b0);
        {an_enable, partner_present} <= 2'b01;
        wait_link(1'b1);
        check(32'({speed_100, full_duplex}), 32'h0000_0000);
        count_rises(400, 10);
        send(8'h3c);
        check(32'(codes[0]), 32'h0000_000c);
        check(32'(codes[1]), 32'h0000_0003);
        check(32'(errs[0] | errs[1]), 32'h0000_0000);
        symbol_mode <= 1'b1;
        wr(pmt_pkg::REG_CTRL, 32'h0000_0002);
        send(8'h16, 1);
        check(32'(codes[0]), 32'h0000_0016);
        // second reset: rmii strap, link-indicator interrupt pin, forced 100 Mbps
        {srst, iface_strap, irq_strap, symbol_mode, forced_speed_100} <= 5'b11101;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        wr(pmt_pkg::REG_CTRL, 32'h0000_0001);
        send(8'h3c);
        check(32'(codes[0]), 32'h0000_001a);
        check(32'(codes[1]), 32'h0000_0015);
        check(32'(rmii_mode), 32'h0000_0001);
        check(32'(lnk_if.interrupt_n_level), 32'h0000_0000);
        count_rises(80, 0);
        summarize();
    end
endmodule : testbench

`default_nettype wire
